// File: rtl/exec_defines.svh
`ifndef EXEC_DEFINES_SVH
`define EXEC_DEFINES_SVH
// Opcode field of the decoded instruction (op_code_in)
`define OP_NOP 3'h0
`define OP_STORE_SFR 3'h1
`define OP_CALL 3'h2
`define OP_JUMP 3'h3
`define OP_LOAD_IMM 3'h4
`define OP_MOVE_TO_FILE 3'h5
`define OP_MOVE_FILE 3'h6
// Cycle counts
`define CYC_ONE 2'h1
`define CYC_TWO 2'h2
// Reset values
`define RST_ACC 8'h00
`define RST_PC 10'h000
`define RST_SP 3'h0
`endif

// File: rtl/exec_pkg.sv
package exec_pkg;
  typedef enum logic [1:0] {ST_FETCH, ST_SECOND} exec_state_t;
endpackage

// File: rtl/return_stack.sv
`include "exec_defines.svh"
// ==================================================
// Return stack: flip-flop storage indexed by level
module return_stack #(
  parameter int DEPTH = 8,
  parameter int AW = 10
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic push_in,
  input wire logic [$clog2(DEPTH)-1:0] level_in,
  input wire logic [AW-1:0] data_in,
  output logic [AW-1:0] top_out
);
  localparam int LW = $clog2(DEPTH);
  logic [AW-1:0] mem_ff [DEPTH];
  logic [AW-1:0] nxt_mem [DEPTH];
  logic [AW-1:0] top_ff;
  logic [AW-1:0] nxt_top;

  if (DEPTH < 2) begin : g_depth_check
    $error("return_stack needs at least two levels");
  end

  // Write selected level on push
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_lvl
      always_comb begin
        nxt_mem[g] = mem_ff[g];
        if (push_in && level_in == LW'(g)) nxt_mem[g] = data_in;
      end
      always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) mem_ff[g] <= '0;
        else mem_ff[g] <= nxt_mem[g];
      end
    end
  endgenerate

  // Last pushed entry, registered so the output comes from a flop
  always_comb begin
    nxt_top = top_ff;
    if (push_in) nxt_top = data_in;
  end
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) top_ff <= '0;
    else top_ff <= nxt_top;
  end
  assign top_out = top_ff;
endmodule

// File: rtl/move_branch_exec.sv
`include "exec_defines.svh"
module move_branch_exec
  import exec_pkg::*;
#(
  parameter int STACK_DEPTH = 8
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic instr_valid_in,
  input wire logic [2:0] op_code_in,
  input wire logic [9:0] operand_in,
  input wire logic dest_sel_in,
  input wire logic [7:0] file_rdata_in,
  output logic busy_out,
  output logic [7:0] accumulator_out,
  output logic zero_flag_out,
  output logic [9:0] pc_out,
  output logic [$clog2(STACK_DEPTH):0] stack_ptr_out,
  output logic [9:0] stack_top_out,
  output logic sfr_we_out,
  output logic [3:0] sfr_addr_out,
  output logic [7:0] sfr_wdata_out,
  output logic file_we_out,
  output logic [5:0] file_addr_out,
  output logic [7:0] file_wdata_out
);
  localparam int SPW = $clog2(STACK_DEPTH);
  // Pointer step sized to the pointer, so the increment neither pads nor cuts
  localparam logic [SPW:0] SP_STEP = (SPW+1)'(1);

  // ==================================================
  // Parameter checks
  // Deeper stacks than 64 levels are not served by this core
  if (STACK_DEPTH < 2 || STACK_DEPTH > 64) begin : g_depth_range
    $error("STACK_DEPTH out of range");
  end
  // The level index is the low pointer bits, so a ragged depth would run past the last level
  if ((STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_depth_pow2
    $error("STACK_DEPTH must be a power of two");
  end

  // ==================================================
  // Architectural state
  exec_state_t state_ff, nxt_state;
  // Busy has a flop of its own so the port never sees a state decode
  logic busy_ff, nxt_busy;
  // Programmer-visible accumulator and zero flag
  logic [7:0] acc_ff, nxt_acc;
  logic zero_ff, nxt_zero;
  // Branch bookkeeping
  logic [9:0] pc_ff, nxt_pc;
  logic [SPW:0] sp_ff, nxt_sp;
  logic [9:0] target_ff, nxt_target;
  // Write ports towards the secondary-page registers and the data file
  logic sfr_we_ff, nxt_sfr_we;
  logic [3:0] sfr_addr_ff, nxt_sfr_addr;
  logic [7:0] sfr_wdata_ff, nxt_sfr_wdata;
  logic file_we_ff, nxt_file_we;
  logic [5:0] file_addr_ff, nxt_file_addr;
  logic [7:0] file_wdata_ff, nxt_file_wdata;
  // Internal request and return address
  logic push;
  logic [9:0] ret_addr;

  // ==================================================
  // Decoding
  // Decoding of a taken instruction, used by the call push request
  function automatic logic is_op(input logic v, input logic [2:0] op, input logic [2:0] want);
    return v && (op == want);
  endfunction

  // Return address is the next instruction; the adder wraps at the top of program space
  assign ret_addr = pc_ff + 10'h001;
  // Pushing only in the first cycle of a call, so the level is the pre-call pointer
  assign push = (state_ff == ST_FETCH) && is_op(instr_valid_in, op_code_in, `OP_CALL);

  // ==================================================
  // Execution next-state
  always_comb begin
    nxt_state = state_ff;
    nxt_busy = 1'b0;
    nxt_acc = acc_ff;
    nxt_zero = zero_ff;
    nxt_pc = pc_ff;
    nxt_sp = sp_ff;
    nxt_target = target_ff;
    nxt_sfr_we = 1'b0;
    nxt_sfr_addr = sfr_addr_ff;
    nxt_sfr_wdata = sfr_wdata_ff;
    nxt_file_we = 1'b0;
    nxt_file_addr = file_addr_ff;
    nxt_file_wdata = file_wdata_ff;
    case (state_ff)
      ST_FETCH: begin
        if (instr_valid_in) begin
          // Every taken instruction advances the counter; a branch overwrites it next cycle
          nxt_pc = ret_addr;
          case (op_code_in)
            `OP_STORE_SFR: begin
              // Status is untouched; only the write port moves
              nxt_sfr_we = 1'b1;
              nxt_sfr_addr = operand_in[3:0];
              nxt_sfr_wdata = acc_ff;
            end
            `OP_CALL: begin
              // Return address goes to the stack this cycle, at the pre-call level
              nxt_sp = sp_ff + SP_STEP;
              nxt_target = operand_in;
              nxt_state = ST_SECOND;
              nxt_busy = 1'b1;
            end
            `OP_JUMP: begin
              // No stack traffic; only the counter changes
              nxt_target = operand_in;
              nxt_state = ST_SECOND;
              nxt_busy = 1'b1;
            end
            `OP_LOAD_IMM: nxt_acc = operand_in[7:0];
            `OP_MOVE_TO_FILE: begin
              // Flags stay as they are
              nxt_file_we = 1'b1;
              nxt_file_addr = operand_in[5:0];
              nxt_file_wdata = acc_ff;
            end
            `OP_MOVE_FILE: begin
              // Zero flag follows the moved value either way
              nxt_zero = (file_rdata_in == 8'h00);
              if (dest_sel_in) begin
                // Writing back lets software test a register for zero
                nxt_file_we = 1'b1;
                nxt_file_addr = operand_in[5:0];
                nxt_file_wdata = file_rdata_in;
              end else begin
                nxt_acc = file_rdata_in;
              end
            end
            default: ;
          endcase
        end
      end
      ST_SECOND: begin
        // Second cycle of a branch: target lands in the counter
        // A request seen in this cycle is dropped; busy_out is high in this cycle to tell the sender
        nxt_pc = target_ff;
        nxt_state = ST_FETCH;
      end
      default: nxt_state = ST_FETCH;
    endcase
  end

  // Overflow of the stack pointer wraps; software must bound nesting
  always_ff @(posedge ref_clk_in) begin
    // Write strobes come out of reset low, so no stray write follows it
    if (sys_rst_in) begin
      state_ff <= ST_FETCH;
      busy_ff <= 1'b0;
      acc_ff <= `RST_ACC;
      zero_ff <= 1'b0;
      pc_ff <= `RST_PC;
      sp_ff <= '0;
      target_ff <= '0;
      sfr_we_ff <= 1'b0;
      sfr_addr_ff <= '0;
      sfr_wdata_ff <= '0;
      file_we_ff <= 1'b0;
      file_addr_ff <= '0;
      file_wdata_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      busy_ff <= nxt_busy;
      acc_ff <= nxt_acc;
      zero_ff <= nxt_zero;
      pc_ff <= nxt_pc;
      sp_ff <= nxt_sp;
      target_ff <= nxt_target;
      sfr_we_ff <= nxt_sfr_we;
      sfr_addr_ff <= nxt_sfr_addr;
      sfr_wdata_ff <= nxt_sfr_wdata;
      file_we_ff <= nxt_file_we;
      file_addr_ff <= nxt_file_addr;
      file_wdata_ff <= nxt_file_wdata;
    end
  end

  // ==================================================
  // Return stack
  // Nesting past the depth wraps the level and overwrites the oldest return address
  return_stack #(.DEPTH(STACK_DEPTH), .AW(10)) u_stack (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .push_in(push),
    .level_in(sp_ff[SPW-1:0]),
    .data_in(ret_addr),
    .top_out(stack_top_out)
  );

  // ==================================================
  // Outputs straight from flops
  // The stack top port is registered inside the stack module
  assign busy_out = busy_ff;
  assign accumulator_out = acc_ff;
  assign zero_flag_out = zero_ff;
  assign pc_out = pc_ff;
  assign stack_ptr_out = sp_ff;
  assign sfr_we_out = sfr_we_ff;
  assign sfr_addr_out = sfr_addr_ff;
  assign sfr_wdata_out = sfr_wdata_ff;
  assign file_we_out = file_we_ff;
  assign file_addr_out = file_addr_ff;
  assign file_wdata_out = file_wdata_ff;
endmodule

// File: test/move_branch_exec_props.sv
`include "exec_defines.svh"
// ======================================
// Port checker for the move and branch group
module move_branch_exec_props #(
  parameter int STACK_DEPTH = 8
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic instr_valid_in,
  input wire logic [2:0] op_code_in,
  input wire logic [9:0] operand_in,
  input wire logic dest_sel_in,
  input wire logic [7:0] file_rdata_in,
  input wire logic busy_out,
  input wire logic [7:0] accumulator_out,
  input wire logic zero_flag_out,
  input wire logic [9:0] pc_out,
  input wire logic [$clog2(STACK_DEPTH):0] stack_ptr_out,
  input wire logic [9:0] stack_top_out,
  input wire logic sfr_we_out,
  input wire logic [3:0] sfr_addr_out,
  input wire logic [7:0] sfr_wdata_out,
  input wire logic file_we_out,
  input wire logic [5:0] file_addr_out,
  input wire logic [7:0] file_wdata_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  // Requests made while busy are dropped, so only idle ones count
  wire logic take = instr_valid_in && !busy_out;
  sequence s_op(logic [2:0] op); take && op_code_in == op; endsequence
  sequence s_call_mid; busy_out && stack_top_out == $past(pc_out) + 10'h1; endsequence
  sequence s_move(logic d);
    take && op_code_in == `OP_MOVE_FILE && dest_sel_in == d;
  endsequence
  a_sfr_store: assert property (s_op(`OP_STORE_SFR) |=> sfr_we_out
    && sfr_addr_out == 4'($past(operand_in)) && sfr_wdata_out == $past(accumulator_out))
    else $error("secondary register store wrong");
  a_call_push: assert property (s_op(`OP_CALL) |=> s_call_mid
    ##1 (!busy_out && pc_out == $past(operand_in, 2))) else $error("call target wrong");
  a_call_stack: assert property (s_op(`OP_CALL) |=> $stable(zero_flag_out)
    && stack_ptr_out == $past(stack_ptr_out) + 1'b1) else $error("call stack step wrong");
  a_jump_target: assert property (s_op(`OP_JUMP) |=> busy_out ##1 (!busy_out
    && pc_out == $past(operand_in, 2) && stack_ptr_out == $past(stack_ptr_out, 2)))
    else $error("jump wrong");
  a_load_imm: assert property (s_op(`OP_LOAD_IMM) |=> $stable(zero_flag_out)
    && accumulator_out == 8'($past(operand_in))) else $error("immediate load wrong");
  a_acc_file: assert property (s_op(`OP_MOVE_TO_FILE) |=> file_we_out
    && file_addr_out == 6'($past(operand_in)) && file_wdata_out == $past(accumulator_out))
    else $error("accumulator to file wrong");
  a_move_acc: assert property (s_move(1'b0) |=> !file_we_out
    && accumulator_out == $past(file_rdata_in)) else $error("file to accumulator wrong");
  a_move_back: assert property (s_move(1'b1) |=> file_we_out
    && file_wdata_out == $past(file_rdata_in)) else $error("file write back wrong");
  a_zero_flag: assert property (s_op(`OP_MOVE_FILE)
    |=> zero_flag_out == ($past(file_rdata_in) == 8'h00)) else $error("zero flag wrong");
endmodule

bind move_branch_exec move_branch_exec_props #(.STACK_DEPTH(STACK_DEPTH)) i_props (
  .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .instr_valid_in(instr_valid_in),
  .op_code_in(op_code_in), .operand_in(operand_in), .dest_sel_in(dest_sel_in),
  .file_rdata_in(file_rdata_in), .busy_out(busy_out), .accumulator_out(accumulator_out),
  .zero_flag_out(zero_flag_out), .pc_out(pc_out), .stack_ptr_out(stack_ptr_out),
  .stack_top_out(stack_top_out), .sfr_we_out(sfr_we_out), .sfr_addr_out(sfr_addr_out),
  .sfr_wdata_out(sfr_wdata_out), .file_we_out(file_we_out), .file_addr_out(file_addr_out),
  .file_wdata_out(file_wdata_out)
);

// File: test/move_branch_exec_tb.sv
`include "exec_defines.svh"
module move_branch_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in = 1'b0, sys_rst_in = 1'b1, instr_valid_in = 1'b0, dest_sel_in = 1'b0;
  logic [2:0] op_code_in = 3'h0;
  logic [9:0] operand_in = 10'h000;
  logic [7:0] file_rdata_in = 8'h00;
  logic busy_out, zero_flag_out, sfr_we_out, file_we_out;
  logic [7:0] accumulator_out, sfr_wdata_out, file_wdata_out;
  logic [9:0] pc_out, stack_top_out;
  logic [3:0] stack_ptr_out, sfr_addr_out;
  logic [5:0] file_addr_out;
  int miscompares = 0;
  int checks_done = 0;
  logic [9:0] pc_exp = 10'h000;
  move_branch_exec i_move_branch_exec (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .instr_valid_in(instr_valid_in),
    .op_code_in(op_code_in), .operand_in(operand_in), .dest_sel_in(dest_sel_in),
    .file_rdata_in(file_rdata_in), .busy_out(busy_out), .accumulator_out(accumulator_out),
    .zero_flag_out(zero_flag_out), .pc_out(pc_out), .stack_ptr_out(stack_ptr_out),
    .stack_top_out(stack_top_out), .sfr_we_out(sfr_we_out), .sfr_addr_out(sfr_addr_out),
    .sfr_wdata_out(sfr_wdata_out), .file_we_out(file_we_out), .file_addr_out(file_addr_out),
    .file_wdata_out(file_wdata_out)
  );
  // ======================================
  // Clock and shared tasks
  always #2 ref_clk_in = ~ref_clk_in;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One instruction, taken at the second edge; sampled 1 ns later so updates have landed
  task automatic issue(input logic [2:0] op, input logic [9:0] opnd, input logic d,
                       input logic [7:0] rd);
    @(posedge ref_clk_in);
    instr_valid_in <= 1'b1;
    {op_code_in, operand_in, dest_sel_in, file_rdata_in} <= {op, opnd, d, rd};
    @(posedge ref_clk_in);
    instr_valid_in <= 1'b0;
    pc_exp = pc_exp + 10'h1;
    #1;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ======================================
  // Scenarios
  task automatic t_load;
    issue(`OP_LOAD_IMM, 10'h35a, 1'b0, 8'h00);
    chk({zero_flag_out, accumulator_out}, 16'h005a);
    issue(`OP_STORE_SFR, 10'h00f, 1'b0, 8'h00);
    chk({sfr_we_out, sfr_addr_out, sfr_wdata_out}, 16'h1f5a);
    chk(pc_out, pc_exp);
    $display("load and store test done");
  endtask
  // Highest file address, then a zero and a nonzero move so the flag must toggle
  task automatic t_file;
    issue(`OP_MOVE_TO_FILE, 10'h03f, 1'b0, 8'h00);
    chk({zero_flag_out, file_we_out, file_addr_out, file_wdata_out}, 16'h7f5a);
    chk(sfr_we_out, 16'h0000);
    issue(`OP_MOVE_FILE, 10'h007, 1'b0, 8'h00);
    chk({file_we_out, zero_flag_out, accumulator_out}, 16'h0100);
    issue(`OP_MOVE_FILE, 10'h007, 1'b1, 8'h3c);
    chk({file_we_out, file_addr_out, file_wdata_out}, 16'h473c);
    chk({zero_flag_out, accumulator_out}, 16'h0000);
    $display("file move test done");
  endtask
  task automatic t_branch;
    issue(`OP_CALL, 10'h3ff, 1'b0, 8'h00);
    chk({busy_out, stack_ptr_out, stack_top_out}, {1'b1, 4'h1, pc_exp});
    @(posedge ref_clk_in);
    #1;
    chk({busy_out, pc_out}, 16'h03ff);
    issue(`OP_JUMP, 10'h155, 1'b0, 8'h00);
    chk(busy_out, 16'h0001);
    @(posedge ref_clk_in);
    #1;
    chk({busy_out, stack_ptr_out, pc_out}, {1'b0, 4'h1, 10'h155});
    $display("branch test done");
  endtask
  // ======================================
  // Main sequence and watchdog; the run needs about 20 cycles
  initial begin
    repeat (4) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    t_load();
    t_file();
    t_branch();
    give_verdict();
  end
  initial begin
    #2000;
    miscompares++;
    give_verdict();
  end
endmodule
